// ---- hw/ptpf_pkg.sv ----
// Constants for the pulse-train position feedback block.
// Assumes a single 25 MHz core clock and a plain strobe register port.
package ptpf_pkg;
  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_IN_FUNC_LO = 8'h04;
  localparam logic [7:0] ADDR_IN_FUNC_HI = 8'h08;
  localparam logic [7:0] ADDR_OUT_FUNC_LO = 8'h0C;
  localparam logic [7:0] ADDR_OUT_FUNC_HI = 8'h10;
  localparam logic [7:0] ADDR_ENC_RES = 8'h14;
  localparam logic [7:0] ADDR_LOOP_GAIN = 8'h18;
  localparam logic [7:0] ADDR_DET_LEVEL = 8'h1C;
  localparam logic [7:0] ADDR_POLES = 8'h20;
  localparam logic [7:0] ADDR_DEVIATION = 8'h24;
  localparam logic [7:0] ADDR_FREQ_CMD = 8'h28;
  localparam logic [7:0] ADDR_ACT_FREQ = 8'h2C;
  localparam logic [7:0] ADDR_PULSE_FREQ = 8'h30;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h34;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h38;
  // Control register fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_FMT_LSB = 2;
  localparam int CTRL_FSRC_LSB = 8;
  localparam int CTRL_OPA_LSB = 12;
  localparam int CTRL_OPB_LSB = 16;
  localparam int CTRL_PV_LSB = 20;
  // Mode and source codes
  typedef enum logic [1:0] {
    PTPF_SPEED_LOOP = 2'h0,
    PTPF_RELATIVE_POS = 2'h1,
    PTPF_ABSOLUTE_POS = 2'h2,
    PTPF_FINE_ABSOLUTE_POS = 2'h3
  } ptpf_mode_t;
  localparam logic [1:0] FMT_QUADRATURE = 2'h0;
  localparam logic [1:0] FMT_PULSE_DIR = 2'h1;
  localparam logic [1:0] FMT_DUAL_PULSE = 2'h2;
  localparam logic [3:0] FSRC_PULSE_TRAIN = 4'h6;
  localparam logic [3:0] FSRC_ARITH = 4'hA;
  localparam logic [3:0] OPSEL_PULSE_TRAIN = 4'h5;
  localparam logic [3:0] PVSRC_PULSE_TRAIN = 4'h3;
  // Terminal function codes (decimal 47, 48, 22)
  localparam logic [7:0] FUNC_DEV_CLEAR = 8'h2F;
  localparam logic [7:0] FUNC_CMD_ENABLE = 8'h30;
  localparam logic [7:0] FUNC_SPEED_DEV = 8'h16;
  localparam logic [7:0] FUNC_NONE = 8'hFF;
  // Setting limits, units of 0.01 except PPR_MIN in pulses
  localparam logic [15:0] LEVEL_MAX = 16'h2EE0;
  localparam logic [15:0] FINE_STEP_LIMIT = 16'h2710;
  localparam logic [15:0] COARSE_STEP = 16'h000A;
  localparam logic [15:0] GAIN_MAX = 16'h2710;
  localparam logic [15:0] PPR_MIN = 16'h0080;
  // Reset values
  localparam logic [15:0] PPR_RESET = 16'h0400;
  localparam logic [15:0] GAIN_RESET = 16'h0064;
  localparam logic [15:0] LEVEL_RESET = 16'h01F4;
  localparam logic [3:0] POLES_RESET = 4'h4;
  // Interrupt bits
  localparam int IRQ_DSE_RISE = 0;
  localparam int IRQ_DEV_CLEARED = 1;
  localparam int IRQ_BITS = 2;
  // Measurement gate
  localparam int CLK_HZ = 25_000_000;
  localparam int GATE_TIME_MS = 100;
  localparam int GATE_CYCLES = CLK_HZ / 1000 * GATE_TIME_MS;
  localparam int PULSE_SCALE = 100_000 / GATE_TIME_MS;
  localparam int ENC_SCALE = 100_000 / (8 * GATE_TIME_MS);
endpackage

// ---- hw/ptpf_top.sv ----
// Pulse-train position feedback logic: command decode, deviation, speed check.
// Assumes pin inputs synchronous to core_clk and a plain register port.
// Functional notes
// - Mode code picks speed, relative, absolute loops; absolute codes hold the command at zero here
// - Command format: quadrature, pulse/direction, dual pulse
// - Count command pulses only while enable active; pulse train rate counts them regardless
// - Clear-terminal on then off zeroes deviation
// - Raise error when speed departs beyond level
// - Detection level 0 to 120 Hz, stepped
// - Relative mode: command from pulses and encoder
// - Encoder resolution 128 to 65535 scales feedback
// - Loop gain 0 to 100 rad/s scales deviation
// - Pole count only 2, 4, 6, 8, 10
// - Source 06 uses pulse-train frequency
// - Arithmetic operand 05 uses pulse-train frequency
// - Process feedback source 03 uses pulse frequency
// - Speed mode uses selected frequency source
// - Error routable to outputs or alarm relay
// - Actual frequency positive forward, negative reverse
`timescale 1ns/1ps
`default_nettype none
module ptpf_top
  import ptpf_pkg::*;
#(
  parameter int GATE_LEN = GATE_CYCLES,
  parameter int IN_TERMS = 8,
  parameter int OUT_TERMS = 5
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [7:0] bus_addr,
  input wire logic [31:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [31:0] bus_rdata,
  output logic irq,
  input wire logic cmd_a,
  input wire logic cmd_b,
  input wire logic enc_a,
  input wire logic enc_b,
  input wire logic [IN_TERMS-1:0] term_in,
  input wire logic signed [31:0] source_freq,
  input wire logic signed [31:0] operand_a_freq,
  input wire logic signed [31:0] operand_b_freq,
  input wire logic signed [31:0] process_input,
  output logic signed [31:0] freq_command,
  output logic signed [31:0] process_feedback,
  output logic [OUT_TERMS-1:0] out_term,
  output logic alarm_relay
);
  ptpf_mode_t control_mode_select;
  logic [1:0] pulse_format_select;
  logic [3:0] frequency_source_select;
  logic [3:0] arith_operand_a_select;
  logic [3:0] arith_operand_b_select;
  logic [3:0] process_feedback_source;
  logic [7:0] input_terminal_function [IN_TERMS];
  logic [7:0] output_terminal_function [OUT_TERMS];
  logic [7:0] alarm_relay_function;
  logic [15:0] encoder_resolution;
  logic [15:0] position_loop_gain;
  logic [15:0] deviation_detect_level;
  logic [3:0] pole_count;
  logic [IRQ_BITS-1:0] irq_status;
  logic [IRQ_BITS-1:0] irq_mask;
  logic signed [31:0] deviation;
  logic signed [31:0] actual_frequency_monitor;
  logic signed [31:0] pulse_freq;
  logic speed_deviation_error;
  logic cmd_a_q, cmd_b_q, enc_a_q, enc_b_q;
  logic clear_q;
  logic [31:0] gate_cnt;
  logic gate_tick;
  logic signed [31:0] cmd_win, enc_win;
  logic [IN_TERMS-1:0] enable_hit, clear_hit;
  logic cmd_enable, clear_level, clear_fire;
  logic signed [1:0] cmd_step, enc_step, raw_cmd_step;
  logic signed [31:0] loop_freq, arith_freq, next_freq_cmd;
  logic signed [32:0] speed_diff;
  logic [32:0] speed_abs;
  logic dse_over;
  logic [15:0] level_in;
  logic [15:0] gain_in;
  logic [15:0] ppr_eff;

  function automatic logic signed [1:0] quad_step(input logic [1:0] prev, input logic [1:0] cur);
    // Forward when B leads A: 00 -> 01 -> 11 -> 10, pairs are {a,b}
    unique case ({prev, cur})
      4'b00_01, 4'b01_11, 4'b11_10, 4'b10_00: quad_step = 2'sb01;
      4'b01_00, 4'b11_01, 4'b10_11, 4'b00_10: quad_step = -2'sb01;
      default: quad_step = 2'sb00;
    endcase
  endfunction

  // Terminal assignment: any terminal may carry enable or clear
  for (genvar i = 0; i < IN_TERMS; i++) begin : g_in_term
    assign enable_hit[i] = term_in[i] && (input_terminal_function[i] == FUNC_CMD_ENABLE);
    assign clear_hit[i] = term_in[i] && (input_terminal_function[i] == FUNC_DEV_CLEAR);
  end
  assign cmd_enable = |enable_hit;
  assign clear_level = |clear_hit;
  assign clear_fire = clear_q && !clear_level;

  always_comb begin
    raw_cmd_step = 2'sb00;
    unique case (pulse_format_select)
      FMT_PULSE_DIR: begin
        if (cmd_a && !cmd_a_q) begin
          raw_cmd_step = cmd_b ? 2'sb01 : -2'sb01;
        end
      end
      FMT_DUAL_PULSE: begin
        if ((cmd_a && !cmd_a_q) && !(cmd_b && !cmd_b_q)) begin
          raw_cmd_step = 2'sb01;
        end else if ((cmd_b && !cmd_b_q) && !(cmd_a && !cmd_a_q)) begin
          raw_cmd_step = -2'sb01;
        end
      end
      default: raw_cmd_step = quad_step({cmd_a_q, cmd_b_q}, {cmd_a, cmd_b});
    endcase
    cmd_step = cmd_enable ? raw_cmd_step : 2'sb00;
    enc_step = quad_step({enc_a_q, enc_b_q}, {enc_a, enc_b});
  end

  // Write-side clamps keep settings inside their documented ranges
  always_comb begin
    level_in = bus_wdata[15:0];
    if (level_in > LEVEL_MAX) begin
      level_in = LEVEL_MAX;
    end
    if (level_in >= FINE_STEP_LIMIT) begin
      level_in = level_in - (level_in % COARSE_STEP);
    end
    gain_in = (bus_wdata[15:0] > GAIN_MAX) ? GAIN_MAX : bus_wdata[15:0];
    ppr_eff = (encoder_resolution < PPR_MIN) ? PPR_MIN : encoder_resolution;
  end

  // Loop and speed math; divide is wide but runs once per cycle
  always_comb begin
    logic signed [55:0] loop_num;
    logic signed [55:0] loop_quo;
    logic signed [55:0] a_op;
    logic signed [55:0] b_op;
    loop_num = 56'(deviation) * 56'($signed({1'b0, position_loop_gain}))
      * 56'($signed({1'b0, pole_count}));
    loop_quo = loop_num / 56'($signed({1'b0, ppr_eff, 3'b000}));
    loop_freq = 32'(loop_quo);
    a_op = 56'((arith_operand_a_select == OPSEL_PULSE_TRAIN) ? pulse_freq : operand_a_freq);
    b_op = 56'((arith_operand_b_select == OPSEL_PULSE_TRAIN) ? pulse_freq : operand_b_freq);
    arith_freq = 32'(a_op + b_op);
    unique case (control_mode_select)
      PTPF_SPEED_LOOP: begin
        if (frequency_source_select == FSRC_PULSE_TRAIN) begin
          next_freq_cmd = pulse_freq;
        end else if (frequency_source_select == FSRC_ARITH) begin
          next_freq_cmd = arith_freq;
        end else begin
          next_freq_cmd = source_freq;
        end
      end
      PTPF_RELATIVE_POS: next_freq_cmd = loop_freq;
      // Absolute modes are not built here; they hold the drive at zero
      default: next_freq_cmd = 32'sh0000_0000;
    endcase
    speed_diff = 33'(actual_frequency_monitor) - 33'(freq_command);
    speed_abs = speed_diff[32] ? 33'(-speed_diff) : 33'(speed_diff);
    dse_over = speed_abs > 33'(deviation_detect_level);
  end

  // Edge history of pins
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cmd_a_q <= 1'b0;
      cmd_b_q <= 1'b0;
      enc_a_q <= 1'b0;
      enc_b_q <= 1'b0;
      clear_q <= 1'b0;
    end else begin
      cmd_a_q <= cmd_a;
      cmd_b_q <= cmd_b;
      enc_a_q <= enc_a;
      enc_b_q <= enc_b;
      clear_q <= clear_level;
    end
  end

  // Position deviation accumulator
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      deviation <= 32'sh0000_0000;
    end else if (clear_fire) begin
      deviation <= 32'sh0000_0000;
    end else begin
      deviation <= deviation + 32'(cmd_step) - 32'(enc_step);
    end
  end

  // Gate window for frequency measurement
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      gate_cnt <= 32'h0000_0000;
      gate_tick <= 1'b0;
    end else if (gate_cnt == 32'(GATE_LEN - 1)) begin
      gate_cnt <= 32'h0000_0000;
      gate_tick <= 1'b1;
    end else begin
      gate_cnt <= gate_cnt + 32'h0000_0001;
      gate_tick <= 1'b0;
    end
  end

  // Pulse train rate counts raw steps; enable gates only positioning
  always_ff @(posedge core_clk) begin
    logic signed [55:0] enc_num;
    if (sys_rst) begin
      cmd_win <= 32'sh0000_0000;
      enc_win <= 32'sh0000_0000;
      pulse_freq <= 32'sh0000_0000;
      actual_frequency_monitor <= 32'sh0000_0000;
    end else if (gate_tick) begin
      enc_num = 56'(enc_win) * 56'($signed({1'b0, pole_count})) * 56'(ENC_SCALE);
      cmd_win <= 32'(raw_cmd_step);
      enc_win <= 32'(enc_step);
      pulse_freq <= 32'(56'(cmd_win) * 56'(PULSE_SCALE));
      actual_frequency_monitor <= 32'(enc_num / 56'($signed({1'b0, ppr_eff})));
    end else begin
      cmd_win <= cmd_win + 32'(raw_cmd_step);
      enc_win <= enc_win + 32'(enc_step);
    end
  end

  // Outputs from flops
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      freq_command <= 32'sh0000_0000;
      process_feedback <= 32'sh0000_0000;
      speed_deviation_error <= 1'b0;
      alarm_relay <= 1'b0;
    end else begin
      freq_command <= next_freq_cmd;
      process_feedback <= (process_feedback_source == PVSRC_PULSE_TRAIN) ? pulse_freq : process_input;
      speed_deviation_error <= dse_over;
      alarm_relay <= dse_over && (alarm_relay_function == FUNC_SPEED_DEV);
    end
  end

  for (genvar j = 0; j < OUT_TERMS; j++) begin : g_out_term
    always_ff @(posedge core_clk) begin
      if (sys_rst) begin
        out_term[j] <= 1'b0;
      end else begin
        out_term[j] <= dse_over && (output_terminal_function[j] == FUNC_SPEED_DEV);
      end
    end
  end

  // Register writes
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      control_mode_select <= PTPF_SPEED_LOOP;
      pulse_format_select <= FMT_QUADRATURE;
      frequency_source_select <= 4'h0;
      arith_operand_a_select <= 4'h0;
      arith_operand_b_select <= 4'h0;
      process_feedback_source <= 4'h0;
      encoder_resolution <= PPR_RESET;
      position_loop_gain <= GAIN_RESET;
      deviation_detect_level <= LEVEL_RESET;
      pole_count <= POLES_RESET;
      irq_mask <= '0;
      alarm_relay_function <= FUNC_NONE;
      for (int k = 0; k < IN_TERMS; k++) begin
        input_terminal_function[k] <= FUNC_NONE;
      end
      for (int k = 0; k < OUT_TERMS; k++) begin
        output_terminal_function[k] <= FUNC_NONE;
      end
    end else if (bus_wr) begin
      unique case (bus_addr)
        ADDR_CTRL: begin
          control_mode_select <= ptpf_mode_t'(bus_wdata[CTRL_MODE_LSB +: 2]);
          // Format code 3 is undefined, so such a write keeps the old format
          if (bus_wdata[CTRL_FMT_LSB +: 2] != 2'h3) begin
            pulse_format_select <= bus_wdata[CTRL_FMT_LSB +: 2];
          end
          frequency_source_select <= bus_wdata[CTRL_FSRC_LSB +: 4];
          arith_operand_a_select <= bus_wdata[CTRL_OPA_LSB +: 4];
          arith_operand_b_select <= bus_wdata[CTRL_OPB_LSB +: 4];
          process_feedback_source <= bus_wdata[CTRL_PV_LSB +: 4];
        end
        ADDR_IN_FUNC_LO: for (int k = 0; k < 4 && k < IN_TERMS; k++) begin
          input_terminal_function[k] <= bus_wdata[8*k +: 8];
        end
        ADDR_IN_FUNC_HI: for (int k = 4; k < IN_TERMS; k++) begin
          input_terminal_function[k] <= bus_wdata[8*(k-4) +: 8];
        end
        ADDR_OUT_FUNC_LO: for (int k = 0; k < 4 && k < OUT_TERMS; k++) begin
          output_terminal_function[k] <= bus_wdata[8*k +: 8];
        end
        ADDR_OUT_FUNC_HI: begin
          for (int k = 4; k < OUT_TERMS; k++) begin
            output_terminal_function[k] <= bus_wdata[8*(k-4) +: 8];
          end
          alarm_relay_function <= bus_wdata[31:24];
        end
        ADDR_ENC_RES: encoder_resolution <= (bus_wdata[15:0] < PPR_MIN) ? PPR_MIN : bus_wdata[15:0];
        ADDR_LOOP_GAIN: position_loop_gain <= gain_in;
        ADDR_DET_LEVEL: deviation_detect_level <= level_in;
        ADDR_POLES: begin
          if (bus_wdata[3:0] inside {4'h2, 4'h4, 4'h6, 4'h8, 4'hA} && bus_wdata[31:4] == 28'h000_0000) begin
            pole_count <= bus_wdata[3:0];
          end
        end
        ADDR_IRQ_MASK: irq_mask <= bus_wdata[IRQ_BITS-1:0];
        default: ;
      endcase
    end
  end

  // Sticky events; a new event beats a same-cycle clear
  always_ff @(posedge core_clk) begin
    logic [IRQ_BITS-1:0] set_ev;
    logic [IRQ_BITS-1:0] clr_ev;
    set_ev = '0;
    set_ev[IRQ_DSE_RISE] = dse_over && !speed_deviation_error;
    set_ev[IRQ_DEV_CLEARED] = clear_fire;
    clr_ev = (bus_wr && bus_addr == ADDR_IRQ_STATUS) ? bus_wdata[IRQ_BITS-1:0] : '0;
    if (sys_rst) begin
      irq_status <= '0;
      irq <= 1'b0;
    end else begin
      irq_status <= (irq_status & ~clr_ev) | set_ev;
      irq <= |(irq_status & irq_mask);
    end
  end

  // Read data, one cycle after the strobe
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      bus_rdata <= 32'h0000_0000;
    end else if (bus_rd) begin
      unique case (bus_addr)
        ADDR_CTRL: bus_rdata <= {8'h00, process_feedback_source, arith_operand_b_select, arith_operand_a_select,
                                 frequency_source_select, 4'h0, pulse_format_select, control_mode_select};
        ADDR_IN_FUNC_LO: bus_rdata <= {input_terminal_function[3], input_terminal_function[2],
                                       input_terminal_function[1], input_terminal_function[0]};
        ADDR_IN_FUNC_HI: bus_rdata <= {input_terminal_function[7], input_terminal_function[6],
                                       input_terminal_function[5], input_terminal_function[4]};
        ADDR_OUT_FUNC_LO: bus_rdata <= {output_terminal_function[3], output_terminal_function[2],
                                        output_terminal_function[1], output_terminal_function[0]};
        ADDR_OUT_FUNC_HI: bus_rdata <= {alarm_relay_function, 16'h0000, output_terminal_function[4]};
        ADDR_ENC_RES: bus_rdata <= {16'h0000, encoder_resolution};
        ADDR_LOOP_GAIN: bus_rdata <= {16'h0000, position_loop_gain};
        ADDR_DET_LEVEL: bus_rdata <= {16'h0000, deviation_detect_level};
        ADDR_POLES: bus_rdata <= {28'h000_0000, pole_count};
        ADDR_DEVIATION: bus_rdata <= deviation;
        ADDR_FREQ_CMD: bus_rdata <= freq_command;
        ADDR_ACT_FREQ: bus_rdata <= actual_frequency_monitor;
        ADDR_PULSE_FREQ: bus_rdata <= pulse_freq;
        ADDR_IRQ_STATUS: bus_rdata <= {30'h0000_0000, irq_status};
        ADDR_IRQ_MASK: bus_rdata <= {30'h0000_0000, irq_mask};
        default: bus_rdata <= 32'h0000_0000;
      endcase
    end else begin
      bus_rdata <= 32'h0000_0000;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  a_cmd_gated: assert property (!cmd_enable && !clear_fire |=> deviation == $past(deviation) - 32'($past(enc_step)))
    else $error("command pulse counted while disabled");
  a_clear_zero: assert property (clear_q && !clear_level |=> deviation == 32'sh0000_0000)
    else $error("deviation not cleared after clear pulse");
  a_dev_accum: assert property (!clear_fire |=> deviation == $past(deviation) + 32'($past(cmd_step)) - 32'($past(enc_step)))
    else $error("deviation accumulator mismatch");
  a_dse_level: assert property (##1 speed_deviation_error == ($past(speed_abs) > 33'($past(deviation_detect_level))))
    else $error("speed deviation error disagrees with level");
  a_level_range: assert property (deviation_detect_level <= LEVEL_MAX
    && (deviation_detect_level < FINE_STEP_LIMIT || deviation_detect_level % COARSE_STEP == 16'h0000))
    else $error("detection level outside range or step");
  a_ppr_min: assert property (encoder_resolution >= PPR_MIN)
    else $error("encoder resolution below minimum");
  a_gain_max: assert property (position_loop_gain <= GAIN_MAX)
    else $error("loop gain above maximum");
  a_poles_legal: assert property (pole_count inside {4'h2, 4'h4, 4'h6, 4'h8, 4'hA})
    else $error("illegal pole count");
  a_pulse_source: assert property (control_mode_select == PTPF_SPEED_LOOP
    && frequency_source_select == FSRC_PULSE_TRAIN |=> freq_command == $past(pulse_freq))
    else $error("pulse source not followed");
  a_dse_route: assert property (output_terminal_function[0] == FUNC_SPEED_DEV |=> out_term[0] == speed_deviation_error)
    else $error("error not routed to terminal");
endmodule // ptpf_top
`default_nettype wire

// ---- bench/ptpf_partner.sv ----
// Command pulse source and shaft encoder driving the block's pins.
// Assumes the bench calls its tasks; pins change just after rising edges.
`timescale 1ns/1ps
`default_nettype none
module ptpf_partner
  import ptpf_pkg::*;
(
  input wire logic core_clk,
  output logic cmd_a,
  output logic cmd_b,
  output logic enc_a,
  output logic enc_b
);
  logic [1:0] gray [4] = '{2'h0, 2'h1, 2'h3, 2'h2};
  int cmd_ph = 0;
  int enc_ph = 0;
  initial begin
    {cmd_a, cmd_b, enc_a, enc_b} = 4'h0;
  end
  // One command step; non-quadrature formats park both pins low after it
  task automatic cmd_step(input logic [1:0] fmt, input bit fwd);
    @(posedge core_clk);
    if (fmt == FMT_QUADRATURE) begin
      cmd_ph = fwd ? (cmd_ph + 1) % 4 : (cmd_ph + 3) % 4;
      {cmd_a, cmd_b} <= gray[cmd_ph];
    end else begin
      cmd_ph = 0;
      // A quadrature leftover would mask the first rising edge; falling edges never count
      if ({cmd_a, cmd_b} != 2'h0) begin
        {cmd_a, cmd_b} <= 2'h0;
        @(posedge core_clk);
      end
      if (fmt == FMT_PULSE_DIR) {cmd_a, cmd_b} <= {1'b1, fwd};
      else {cmd_a, cmd_b} <= {fwd, !fwd};
      @(posedge core_clk);
      {cmd_a, cmd_b} <= 2'h0;
    end
  endtask
  // Forward means B leads A by a quarter cycle
  task automatic enc_step(input bit fwd);
    @(posedge core_clk);
    enc_ph = fwd ? (enc_ph + 1) % 4 : (enc_ph + 3) % 4;
    {enc_a, enc_b} <= gray[enc_ph];
  endtask
endmodule // ptpf_partner
`default_nettype wire

// ---- bench/ptpf_top_tb.sv ----
// Self-checking bench for the pulse-train position feedback block.
// Assumes a 100-cycle measuring gate so rate results come in quickly.
`timescale 1ns/1ps
`default_nettype none
module ptpf_top_tb
  import ptpf_pkg::*;
;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] bus_addr = 8'h00;
  logic [31:0] bus_wdata = 32'h0000_0000;
  logic bus_wr = 1'b0;
  logic bus_rd = 1'b0;
  logic [31:0] bus_rdata;
  logic irq;
  logic cmd_a, cmd_b, enc_a, enc_b;
  logic [7:0] term_in = 8'h00;
  logic signed [31:0] src_f = 0, opa_f = 0, opb_f = 0, pv_in = 0;
  logic signed [31:0] freq_command, process_feedback;
  logic [4:0] out_term;
  logic alarm_relay;
  int miscompares = 0;
  int samples_checked = 0;
  int exp_dev = 0;
  logic [7:0] rst_a [6] = '{ADDR_ENC_RES, ADDR_LOOP_GAIN, ADDR_DET_LEVEL, ADDR_POLES, ADDR_IN_FUNC_LO, 8'h3C};
  logic [31:0] rst_v [6] = '{32'h0000_0400, 32'h0000_0064, 32'h0000_01F4, 32'h0000_0004, 32'hFFFF_FFFF, 0};
  logic [7:0] cl_a [9] = '{ADDR_POLES, ADDR_POLES, ADDR_POLES, ADDR_DET_LEVEL, ADDR_DET_LEVEL, ADDR_DET_LEVEL,
    ADDR_LOOP_GAIN, ADDR_LOOP_GAIN, ADDR_ENC_RES};
  logic [15:0] cl_w [9] = '{16'h0003, 16'h0006, 16'h0004, 16'h32C8, 16'h2715, 16'h270F, 16'h4E20, 16'h0064, 16'h0032};
  logic [15:0] cl_e [9] = '{16'h0004, 16'h0006, 16'h0004, 16'h2EE0, 16'h2710, 16'h270F, 16'h2710, 16'h0064, 16'h0080};
  always #20 core_clk = ~core_clk;
  ptpf_partner u_ptpf_partner (.core_clk(core_clk), .cmd_a(cmd_a), .cmd_b(cmd_b), .enc_a(enc_a), .enc_b(enc_b));
  ptpf_top #(.GATE_LEN(100)) u_ptpf_top (.core_clk(core_clk), .sys_rst(sys_rst), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .irq(irq), .cmd_a(cmd_a),
    .cmd_b(cmd_b), .enc_a(enc_a), .enc_b(enc_b), .term_in(term_in), .source_freq(src_f), .operand_a_freq(opa_f),
    .operand_b_freq(opb_f), .process_input(pv_in), .freq_command(freq_command),
    .process_feedback(process_feedback), .out_term(out_term), .alarm_relay(alarm_relay));
  task automatic stop_test;
    $display("checks %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_bit(input string nm, input logic e, input logic g);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    {bus_addr, bus_wdata, bus_wr} <= {a, d, 1'b1};
    @(posedge core_clk);
    bus_wr <= 1'b0;
  endtask
  // Three idle edges first so pin-driven results have landed
  task automatic chk_reg(input logic [7:0] a, input logic [31:0] e);
    repeat (3) @(posedge core_clk);
    {bus_addr, bus_rd} <= {a, 1'b1};
    @(posedge core_clk);
    bus_rd <= 1'b0;
    @(negedge core_clk);
    chk_word($sformatf("reg %h", a), e, bus_rdata);
  endtask
  task automatic settle;
    repeat (3) @(negedge core_clk);
  endtask
  task automatic cmd_steps(input logic [1:0] fmt, input int n, input bit fwd, input bit en);
    repeat (n) u_ptpf_partner.cmd_step(fmt, fwd);
    if (en) exp_dev += fwd ? n : -n;
  endtask
  // Steps every 5 cycles: any full 100-cycle gate holds exactly 20
  task automatic run(input bit cmd_on, input bit fwd, input int e_act, input int e_cmd, input bit e_err);
    fork
      repeat (60) begin
        u_ptpf_partner.enc_step(fwd);
        repeat (4) @(posedge core_clk);
      end
      if (cmd_on) repeat (60) begin
        u_ptpf_partner.cmd_step(FMT_PULSE_DIR, 1'b1);
        repeat (3) @(posedge core_clk);
      end
      begin
        repeat (240) @(posedge core_clk);
        chk_reg(ADDR_ACT_FREQ, e_act);
        chk_word("freq_command", e_cmd, freq_command);
        chk_bit("out_term", e_err, out_term[0]);
        chk_bit("alarm_relay", e_err, alarm_relay);
        if (cmd_on) chk_reg(ADDR_PULSE_FREQ, 20000);
        chk_word("process_feedback", cmd_on ? 20000 : pv_in, process_feedback);
      end
    join
  endtask
  initial begin
    repeat (30000) @(posedge core_clk);
    miscompares++;
    stop_test;
  end
  initial begin
    void'($urandom(26));
    // Source frequency stays 0 until its own run, else a speed error latches at reset
    {opa_f, opb_f, pv_in} <= {$urandom_range(1000, 30000), $urandom, $urandom};
    repeat (6) @(posedge core_clk);
    sys_rst <= 1'b0;
    foreach (rst_a[i]) chk_reg(rst_a[i], rst_v[i]);
    for (int i = 0; i < 9; i++) begin
      wr(cl_a[i], {16'h0000, cl_w[i]});
      chk_reg(cl_a[i], {16'h0000, cl_e[i]});
    end
    wr(ADDR_IN_FUNC_LO, 32'hFFFF_2F30);
    wr(ADDR_IRQ_MASK, 32'h0000_0003);
    wr(ADDR_CTRL, 32'h0000_0005);
    cmd_steps(FMT_PULSE_DIR, $urandom_range(3, 9), 1'b1, 1'b0);
    chk_reg(ADDR_DEVIATION, exp_dev);
    term_in[0] <= 1'b1;
    for (int f = 0; f < 3; f++) begin
      wr(ADDR_CTRL, 32'h0000_0001 | (f << 2));
      cmd_steps(f[1:0], $urandom_range(8, 20), 1'b1, 1'b1);
      cmd_steps(f[1:0], $urandom_range(1, 4), 1'b0, 1'b1);
      chk_reg(ADDR_DEVIATION, exp_dev);
    end
    repeat (4) u_ptpf_partner.enc_step(1'b1);
    exp_dev -= 4;
    chk_reg(ADDR_DEVIATION, exp_dev);
    chk_reg(ADDR_FREQ_CMD, exp_dev * 100 * 4 / (8 * 128));
    wr(ADDR_CTRL, 32'h0000_0002);
    settle;
    chk_word("freq_command", 0, freq_command);
    @(posedge core_clk);
    term_in[1] <= 1'b1;
    @(posedge core_clk);
    term_in[1] <= 1'b0;
    chk_reg(ADDR_DEVIATION, 0);
    chk_reg(ADDR_IRQ_STATUS, 32'h0000_0002);
    chk_bit("irq", 1'b1, irq);
    wr(ADDR_IRQ_MASK, 32'h0000_0001);
    settle;
    chk_bit("irq", 1'b0, irq);
    wr(ADDR_IRQ_MASK, 32'h0000_0003);
    wr(ADDR_IRQ_STATUS, 32'h0000_0002);
    chk_reg(ADDR_IRQ_STATUS, 0);
    chk_bit("irq", 1'b0, irq);
    wr(ADDR_OUT_FUNC_LO, 32'hFFFF_FF16);
    wr(ADDR_OUT_FUNC_HI, 32'h16FF_FFFF);
    wr(ADDR_DET_LEVEL, 32'h0000_0064);
    wr(ADDR_CTRL, 32'h0000_0604);
    run(1'b0, 1'b1, 78, 0, 1'b0);
    run(1'b0, 1'b0, -78, 0, 1'b0);
    wr(ADDR_CTRL, 32'h0035_5A04);
    run(1'b1, 1'b1, 78, 40000, 1'b1);
    chk_reg(ADDR_IRQ_STATUS, 32'h0000_0001);
    chk_bit("irq", 1'b1, irq);
    wr(ADDR_IRQ_STATUS, 32'h0000_0001);
    wr(ADDR_CTRL, 32'h0030_0604);
    run(1'b1, 1'b1, 78, 20000, 1'b1);
    wr(ADDR_CTRL, 32'h0035_0A04);
    run(1'b1, 1'b1, 78, opa_f + 20000, 1'b1);
    src_f <= $urandom_range(1000, 30000);
    wr(ADDR_CTRL, 32'h0030_0004);
    run(1'b1, 1'b1, 78, src_f, 1'b1);
    stop_test;
  end
endmodule // ptpf_top_tb
`default_nettype wire
